// File: cwh_regs.vh
// Purpose: register offsets, field positions, reset values for the custom wave half-period control
// Assumes: 8-bit register port, 8-bit data
// Notes: definitions only
`ifndef CWH_REGS_VH
`define CWH_REGS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CWH_ADDR_CTRL      8'h00
`define CWH_ADDR_MAXCUR    8'h01
`define CWH_ADDR_COEF1     8'h02
`define CWH_ADDR_COEF2     8'h03
`define CWH_ADDR_COEF3     8'h04
`define CWH_ADDR_OVERRIDE  8'h05
`define CWH_ADDR_STATUS    8'h06
`define CWH_ADDR_EVT1      8'h08
`define CWH_ADDR_MASK1     8'h09
`define CWH_ADDR_EVT2      8'h0A
`define CWH_ADDR_MASK2     8'h0B
`define CWH_ADDR_LOOP      8'h0C
`define CWH_ADDR_UVLO      8'h0D
`define CWH_ADDR_SLOPE     8'h0E

// ----------------------------------------
// control field positions
// ----------------------------------------
`define CWH_CTRL_SHAPE_SEL  0
`define CWH_CTRL_MOTION     1
`define CWH_CTRL_IMP_HOLD   2
`define CWH_CTRL_AMP_REG    3
`define CWH_CTRL_STANDALONE 4
`define CWH_CTRL_OVERRIDE   5

// ----------------------------------------
// event fields
// ----------------------------------------
`define CWH_EVT1_W       4
`define CWH_EVT1_SHORT   0
`define CWH_EVT1_UV      1
`define CWH_EVT1_ACT     2
`define CWH_EVT1_DONE    3
`define CWH_EVT1_FAULTS  4'h7
`define CWH_EVT2_W       2
`define CWH_EVT2_HALF    0
`define CWH_EVT2_REFUSE  1

// ----------------------------------------
// reset values
// ----------------------------------------
`define CWH_RST_CTRL     8'h02
`define CWH_RST_MAXCUR   5'h1F
`define CWH_RST_COEF1    8'h61
`define CWH_RST_COEF2    8'hB4
`define CWH_RST_COEF3    8'hEC
`define CWH_RST_LOOP     5'h00
`define CWH_RST_UVLO     2'h1
`define CWH_RST_SLOPE    4'hF

// ----------------------------------------
// shape timing
// ----------------------------------------
`define CWH_POINTS       16
`define CWH_POINT_SHIFT  4
`define CWH_MIN_STEP     12'h001

`endif

// File: cwh_shape.v
// Purpose: maps a point index of the resonant period to a signed drive level
// Assumes: coefficients are unsigned fractions of 256
// Notes: purely combinational
`timescale 1ns/1ps
module cwh_shape (
  input wire [4:0] i_max_drive_current,
  input wire [7:0] i_shape_point1_coef,
  input wire [7:0] i_shape_point2_coef,
  input wire [7:0] i_shape_point3_coef,
  input wire [3:0] i_point,
  input wire [7:0] i_envelope,
  output reg [12:0] o_level,
  output wire o_negative
);
  wire [2:0] half_pos;
  wire [2:0] quarter_pos;
  reg [12:0] prod;
  reg [4:0] mag;

  assign half_pos = i_point[2:0];
  // points 5..7 fold back onto 3..1
  assign quarter_pos = (half_pos > 3'h4) ? (3'h0 - half_pos) : half_pos;
  // second half of the period drives the opposite way
  assign o_negative = i_point[3];

  always @* begin
    prod = 13'h0000;
    mag = 5'h00;
    case (quarter_pos)
      3'h0: mag = 5'h00;
      3'h1: begin
        prod = i_max_drive_current * i_shape_point1_coef;
        mag = prod[12:8];
      end
      3'h2: begin
        prod = i_max_drive_current * i_shape_point2_coef;
        mag = prod[12:8];
      end
      3'h3: begin
        prod = i_max_drive_current * i_shape_point3_coef;
        mag = prod[12:8];
      end
      3'h4: mag = i_max_drive_current;
      default: mag = 5'h00;
    endcase
    // envelope from the playback path or the held override scales the whole period
    o_level = mag * i_envelope;
  end
endmodule

// File: cwh_irq.v
// Purpose: sticky event flags with write-one-to-clear, mask and interrupt request
// Assumes: synchronous active-low reset
// Notes: a set in the same cycle as a clear wins
`timescale 1ns/1ps
module cwh_irq #(
  parameter W = 4
) (
  input wire i_core_clk,
  input wire i_nrst,
  input wire [W-1:0] i_set,
  input wire [W-1:0] i_clear,
  input wire [W-1:0] i_mask_wr_data,
  input wire i_mask_wr,
  output reg [W-1:0] o_status,
  output reg [W-1:0] o_mask,
  output wire o_irq
);
  wire [W-1:0] next_status;

  assign next_status = (o_status & ~i_clear) | i_set;
  assign o_irq = |(o_status & ~o_mask);

  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_status <= {W{1'b0}};
      o_mask <= {W{1'b0}};
    end else begin
      o_status <= next_status;
      if (i_mask_wr) begin
        o_mask <= i_mask_wr_data;
      end
    end
  end
endmodule

// File: cwh_ctrl.v
// Purpose: custom resonant-period wave shaping, half-period indicator, standalone fault clearing
// Assumes: register port and playback inputs synchronous to i_core_clk (40 MHz)
// Notes: mask bit 1 blocks the matching event from the interrupt
//
// Overview of operation
// - each period is 16 points, points 0..4 mirrored so symmetric pairs have equal amplitude.
// - point 0 is zero and point 4 is the full maximum drive current.
// - points 1..3 are the maximum current scaled by one unsigned coefficient each.
// - coefficients reset to a sine approximation of about 37.9, 70.3 and 92.2 percent.
// - the shape fixes only the waveform inside a period; frequency comes from playback, envelope from playback or the override.
// - with standalone mode set, every fault is cleared on entering the inactive state.
// - a short circuit stops drive, disables the current loop and goes inactive; standalone clears it.
// - the half-period indicator toggles at the start of every drive half-period.
// - undervoltage threshold defaults to 2.8 V, selectable 2.7 V to 3.0 V in 100 mV steps.
// - each event flag clears by writing one and is maskable through two mask registers.
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "cwh_regs.vh"
module cwh_ctrl (
  input wire i_core_clk,
  input wire i_nrst,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  input wire i_play_start,
  input wire i_play_stop,
  input wire [7:0] i_env_amp,
  input wire [15:0] i_period_cycles,
  input wire i_short_circuit,
  input wire i_undervoltage,
  input wire i_actuator_fault,
  output reg [12:0] o_drive_level,
  output reg o_drive_negative,
  output reg o_current_loop_en,
  output reg o_half_period,
  output wire o_wave_shape_select,
  output wire o_motion_sense_enable,
  output wire o_impedance_factor_hold,
  output wire o_amplitude_regulator_enable,
  output wire [1:0] o_loop_cap_trim,
  output wire [1:0] o_loop_res_trim,
  output wire o_loop_narrow_bandwidth,
  output wire [1:0] o_undervoltage_threshold,
  output wire [1:0] o_lowside_slope_trim,
  output wire [1:0] o_highside_slope_trim,
  output wire o_irq
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_ACTIVE = 1'b1;

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  reg [7:0] ctrl;
  reg [4:0] max_drive_current;
  reg [7:0] shape_point1_coef;
  reg [7:0] shape_point2_coef;
  reg [7:0] shape_point3_coef;
  reg [7:0] override_amplitude;
  reg [4:0] loop_cfg;
  reg [1:0] undervoltage_threshold;
  reg [3:0] slope_cfg;

  wire wr_ctrl = i_wr && (i_addr == `CWH_ADDR_CTRL);
  wire wr_evt1 = i_wr && (i_addr == `CWH_ADDR_EVT1);
  wire wr_evt2 = i_wr && (i_addr == `CWH_ADDR_EVT2);
  wire wr_mask1 = i_wr && (i_addr == `CWH_ADDR_MASK1);
  wire wr_mask2 = i_wr && (i_addr == `CWH_ADDR_MASK2);

  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      ctrl <= `CWH_RST_CTRL;
      max_drive_current <= `CWH_RST_MAXCUR;
      shape_point1_coef <= `CWH_RST_COEF1;
      shape_point2_coef <= `CWH_RST_COEF2;
      shape_point3_coef <= `CWH_RST_COEF3;
      override_amplitude <= 8'h00;
      loop_cfg <= `CWH_RST_LOOP;
      undervoltage_threshold <= `CWH_RST_UVLO;
      slope_cfg <= `CWH_RST_SLOPE;
    end else if (i_wr) begin
      case (i_addr)
        `CWH_ADDR_CTRL: ctrl <= {2'h0, i_wdata[5:0]};
        `CWH_ADDR_MAXCUR: max_drive_current <= i_wdata[4:0];
        `CWH_ADDR_COEF1: shape_point1_coef <= i_wdata;
        `CWH_ADDR_COEF2: shape_point2_coef <= i_wdata;
        `CWH_ADDR_COEF3: shape_point3_coef <= i_wdata;
        `CWH_ADDR_OVERRIDE: override_amplitude <= i_wdata;
        `CWH_ADDR_LOOP: loop_cfg <= i_wdata[4:0];
        `CWH_ADDR_UVLO: undervoltage_threshold <= i_wdata[1:0];
        `CWH_ADDR_SLOPE: slope_cfg <= i_wdata[3:0];
        default: ctrl <= ctrl;
      endcase
    end
  end

  assign o_wave_shape_select = ctrl[`CWH_CTRL_SHAPE_SEL];
  assign o_motion_sense_enable = ctrl[`CWH_CTRL_MOTION];
  assign o_impedance_factor_hold = ctrl[`CWH_CTRL_IMP_HOLD];
  assign o_amplitude_regulator_enable = ctrl[`CWH_CTRL_AMP_REG];
  assign o_loop_cap_trim = loop_cfg[1:0];
  assign o_loop_res_trim = loop_cfg[3:2];
  assign o_loop_narrow_bandwidth = loop_cfg[4];
  // code 0 is 2.7 V, each step adds 100 mV up to 3.0 V
  assign o_undervoltage_threshold = undervoltage_threshold;
  // code 0 is 25 mV/ns, code 3 is 100 mV/ns
  assign o_lowside_slope_trim = slope_cfg[1:0];
  assign o_highside_slope_trim = slope_cfg[3:2];

  wire standalone = ctrl[`CWH_CTRL_STANDALONE];
  wire override_on = ctrl[`CWH_CTRL_OVERRIDE];

  // ----------------------------------------
  // events and interrupt
  // ----------------------------------------
  wire [`CWH_EVT1_W-1:0] evt1_status;
  wire [`CWH_EVT1_W-1:0] evt1_mask;
  wire [`CWH_EVT2_W-1:0] evt2_status;
  wire [`CWH_EVT2_W-1:0] evt2_mask;
  wire irq1;
  wire irq2;
  reg [`CWH_EVT1_W-1:0] evt1_set;
  reg [`CWH_EVT2_W-1:0] evt2_set;
  reg auto_clear;
  wire [`CWH_EVT1_W-1:0] evt1_clear;
  wire [`CWH_EVT2_W-1:0] evt2_clear;

  assign evt1_clear = (wr_evt1 ? i_wdata[`CWH_EVT1_W-1:0] : 4'h0) |
                      (auto_clear ? `CWH_EVT1_FAULTS : 4'h0);
  assign evt2_clear = wr_evt2 ? i_wdata[`CWH_EVT2_W-1:0] : 2'h0;

  cwh_irq #(.W(`CWH_EVT1_W)) u_irq1 (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_set(evt1_set),
    .i_clear(evt1_clear),
    .i_mask_wr_data(i_wdata[`CWH_EVT1_W-1:0]),
    .i_mask_wr(wr_mask1),
    .o_status(evt1_status),
    .o_mask(evt1_mask),
    .o_irq(irq1)
  );

  cwh_irq #(.W(`CWH_EVT2_W)) u_irq2 (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_set(evt2_set),
    .i_clear(evt2_clear),
    .i_mask_wr_data(i_wdata[`CWH_EVT2_W-1:0]),
    .i_mask_wr(wr_mask2),
    .o_status(evt2_status),
    .o_mask(evt2_mask),
    .o_irq(irq2)
  );

  assign o_irq = irq1 | irq2;

  // ----------------------------------------
  // playback state
  // ----------------------------------------
  reg state;
  reg next_state;
  reg was_active;
  reg [11:0] step_cnt;
  reg [3:0] point;
  reg [7:0] held_override;
  wire fault_in = i_short_circuit | i_undervoltage | i_actuator_fault;
  wire faults_pending = |(evt1_status & `CWH_EVT1_FAULTS);
  wire [11:0] step_len = (i_period_cycles[15:4] == 12'h000) ? `CWH_MIN_STEP : i_period_cycles[15:4];
  wire step_end = (step_cnt >= step_len - 12'h001);
  wire half_start;
  wire start_ok = i_play_start && !faults_pending && !fault_in;

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_ok) begin
          next_state = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (fault_in || i_play_stop) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // half-period begins at point 0 and point 8, including the first point of drive
  assign half_start = (state == ST_IDLE) ? start_ok :
                      (step_end && (point[2:0] == 3'h7) && (next_state == ST_ACTIVE));

  always @* begin
    evt1_set = 4'h0;
    evt1_set[`CWH_EVT1_SHORT] = i_short_circuit;
    evt1_set[`CWH_EVT1_UV] = i_undervoltage;
    evt1_set[`CWH_EVT1_ACT] = i_actuator_fault;
    evt1_set[`CWH_EVT1_DONE] = (state == ST_ACTIVE) && i_play_stop && !fault_in;
    evt2_set = 2'h0;
    evt2_set[`CWH_EVT2_HALF] = half_start;
    evt2_set[`CWH_EVT2_REFUSE] = (state == ST_IDLE) && i_play_start && !start_ok;
  end

  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      state <= ST_IDLE;
      was_active <= 1'b0;
      auto_clear <= 1'b0;
      step_cnt <= 12'h000;
      point <= 4'h0;
      held_override <= 8'h00;
      o_half_period <= 1'b0;
    end else begin
      state <= next_state;
      was_active <= (state == ST_ACTIVE);
      // one cycle after going inactive, so a fault latched on the way down is cleared too
      auto_clear <= standalone && (state == ST_IDLE) && was_active;
      if (half_start) begin
        o_half_period <= ~o_half_period;
        held_override <= override_amplitude;
      end
      if (next_state != ST_ACTIVE) begin
        step_cnt <= 12'h000;
        point <= 4'h0;
      end else if (state == ST_ACTIVE) begin
        if (step_end) begin
          step_cnt <= 12'h000;
          point <= point + 4'h1;
        end else begin
          step_cnt <= step_cnt + 12'h001;
        end
      end
    end
  end

  // ----------------------------------------
  // drive output
  // ----------------------------------------
  wire [12:0] shape_level;
  wire shape_negative;
  // override amplitude is taken at each half-period start so a late write waits for the next one
  wire [7:0] envelope = override_on ? held_override : i_env_amp;

  cwh_shape u_shape (
    .i_max_drive_current(max_drive_current),
    .i_shape_point1_coef(shape_point1_coef),
    .i_shape_point2_coef(shape_point2_coef),
    .i_shape_point3_coef(shape_point3_coef),
    .i_point(point),
    .i_envelope(envelope),
    .o_level(shape_level),
    .o_negative(shape_negative)
  );

  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_drive_level <= 13'h0000;
      o_drive_negative <= 1'b0;
      o_current_loop_en <= 1'b0;
    end else begin
      o_current_loop_en <= (next_state == ST_ACTIVE);
      if (next_state == ST_ACTIVE && state == ST_ACTIVE) begin
        o_drive_level <= shape_level;
        o_drive_negative <= shape_negative;
      end else begin
        o_drive_level <= 13'h0000;
        o_drive_negative <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `CWH_ADDR_CTRL: o_rdata <= ctrl;
        `CWH_ADDR_MAXCUR: o_rdata <= {3'h0, max_drive_current};
        `CWH_ADDR_COEF1: o_rdata <= shape_point1_coef;
        `CWH_ADDR_COEF2: o_rdata <= shape_point2_coef;
        `CWH_ADDR_COEF3: o_rdata <= shape_point3_coef;
        `CWH_ADDR_OVERRIDE: o_rdata <= override_amplitude;
        `CWH_ADDR_STATUS: o_rdata <= {6'h00, state, o_half_period};
        `CWH_ADDR_EVT1: o_rdata <= {4'h0, evt1_status};
        `CWH_ADDR_MASK1: o_rdata <= {4'h0, evt1_mask};
        `CWH_ADDR_EVT2: o_rdata <= {6'h00, evt2_status};
        `CWH_ADDR_MASK2: o_rdata <= {6'h00, evt2_mask};
        `CWH_ADDR_LOOP: o_rdata <= {3'h0, loop_cfg};
        `CWH_ADDR_UVLO: o_rdata <= {6'h00, undervoltage_threshold};
        `CWH_ADDR_SLOPE: o_rdata <= {4'h0, slope_cfg};
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end
endmodule

// File: cwh_ctrl_chk.sv
// Purpose: port-level assertions for cwh_ctrl
// Assumes: one clock domain, synchronous active-low reset
// Notes: i_period_cycles is held steady while a playback runs
`timescale 1ns/1ps
module cwh_ctrl_chk (
  input wire i_core_clk,
  input wire i_nrst,
  input wire i_rd,
  input wire i_play_start,
  input wire i_play_stop,
  input wire [15:0] i_period_cycles,
  input wire i_short_circuit,
  input wire i_undervoltage,
  input wire i_actuator_fault,
  input wire [7:0] o_rdata,
  input wire [12:0] o_drive_level,
  input wire o_drive_negative,
  input wire o_current_loop_en,
  input wire o_half_period,
  input wire o_motion_sense_enable,
  input wire [1:0] o_undervoltage_threshold,
  input wire [1:0] o_lowside_slope_trim,
  input wire [1:0] o_highside_slope_trim,
  input wire o_irq
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  reg [19:0] since_half;
  wire [11:0] step = (i_period_cycles[15:4] == 12'h000) ? 12'h001 : i_period_cycles[15:4];
  wire fault_in = i_short_circuit | i_undervoltage | i_actuator_fault;
  // counts edges since the indicator last moved; only compared after a toggle inside a run
  always @(posedge i_core_clk) begin
    if ($changed(o_half_period)) begin
      since_half <= 20'h0_0000;
    end else begin
      since_half <= since_half + 20'h0_0001;
    end
  end
  sequence s_start;
    $rose(o_current_loop_en);
  endsequence
  sequence s_mid_toggle;
    o_current_loop_en && $changed(o_half_period) && !$rose(o_current_loop_en);
  endsequence
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_rdata_read_slot: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside its slot");
  a_start_has_cause: assert property (s_start |-> $past(i_play_start))
    else $error("drive began without a request");
  a_start_point_zero: assert property (s_start |-> $changed(o_half_period) && o_drive_level == 13'h0000 && !o_drive_negative)
    else $error("run did not open at point zero with a toggle");
  a_half_spacing: assert property (s_mid_toggle |-> since_half == {5'h00, step, 3'h0} - 20'h0_0001)
    else $error("half-period toggle spacing wrong");
  a_polarity_flip: assert property (s_mid_toggle |=> !o_current_loop_en || $changed(o_drive_negative))
    else $error("polarity did not follow the half-period");
  a_fault_stops: assert property (o_current_loop_en && fault_in |=> !o_current_loop_en && o_drive_level == 13'h0000)
    else $error("fault did not stop the drive");
  a_stop_idles: assert property (o_current_loop_en && i_play_stop |=> !o_current_loop_en)
    else $error("stop did not end the run");
  a_idle_no_drive: assert property (!o_current_loop_en |-> o_drive_level == 13'h0000)
    else $error("drive level while inactive");
  a_reset_trims: assert property ($rose(i_nrst) |-> o_undervoltage_threshold == 2'h1
    && o_lowside_slope_trim == 2'h3 && o_highside_slope_trim == 2'h3 && o_motion_sense_enable && !o_irq
    && !o_current_loop_en)
    else $error("outputs wrong after reset");
endmodule

bind cwh_ctrl cwh_ctrl_chk cwh_ctrl_chk_i (.*);

// File: cwh_host.sv
// Purpose: host processor model driving the register port
// Assumes: strobes one cycle long, read data taken one edge later
// Notes: released address and data lines show the inverse of their last value
`timescale 1ns/1ps
`include "cwh_regs.vh"
module cwh_host (
  input wire i_core_clk,
  input wire [7:0] i_rdata,
  output reg [7:0] o_addr,
  output reg [7:0] o_wdata,
  output reg o_wr,
  output reg o_rd
);
  initial begin
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge i_core_clk);
      o_addr <= a;
      o_wdata <= d;
      o_wr <= 1'b1;
      @(posedge i_core_clk);
      o_wr <= 1'b0;
      o_addr <= ~a;
      o_wdata <= ~d;
    end
  endtask
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(posedge i_core_clk);
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_core_clk);
      o_rd <= 1'b0;
      o_addr <= ~a;
      @(posedge i_core_clk);
      d = i_rdata;
    end
  endtask
  // ----------------------------------------
  // setup sequences
  // ----------------------------------------
  // custom shape on, motion sensing off, impedance held, regulator off
  task setup_custom(input standalone, input ovr);
    wr(`CWH_ADDR_CTRL, {2'h0, ovr, standalone, 4'h5});
  endtask
  // the override value is written only while idle, ahead of the first half-period start
  task set_override(input [7:0] v);
    wr(`CWH_ADDR_OVERRIDE, v);
  endtask
  task loop_setup(input integer r_ohm, input integer l_uh, input [1:0] res_trim);
    reg [1:0] cap;
    begin
      cap = (r_ohm < 18) ? 2'h3 : (r_ohm < 28) ? 2'h2 : (r_ohm < 41) ? 2'h1 : 2'h0;
      wr(`CWH_ADDR_LOOP, {3'h0, l_uh > 1000, res_trim, cap});
    end
  endtask
endmodule

// File: cwh_ctrl_test.sv
// Purpose: self-checking bench for cwh_ctrl
// Assumes: 40 MHz clock, step length of 4 clocks per point except in the short-period case
// Notes: random shapes from a fixed seed, corner cases written by hand
`timescale 1ns/1ps
`include "cwh_regs.vh"
`define CHK(g, e) begin \
  n_tests = n_tests + 1; \
  if ((g) !== (e)) begin \
    fails = fails + 1; \
    $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); \
  end \
end
module cwh_ctrl_test;
  reg i_core_clk;
  reg i_nrst;
  reg [4:0] ev;
  reg [7:0] i_env_amp;
  reg [15:0] i_period_cycles;
  wire i_play_start = ev[0];
  wire i_play_stop = ev[1];
  wire i_short_circuit = ev[2];
  wire i_undervoltage = ev[3];
  wire i_actuator_fault = ev[4];
  wire [7:0] i_addr, i_wdata, o_rdata;
  wire i_wr, i_rd, o_drive_negative, o_current_loop_en, o_half_period, o_irq;
  wire [12:0] o_drive_level;
  wire o_wave_shape_select, o_motion_sense_enable, o_impedance_factor_hold, o_amplitude_regulator_enable;
  wire o_loop_narrow_bandwidth;
  wire [1:0] o_loop_cap_trim, o_loop_res_trim, o_undervoltage_threshold, o_lowside_slope_trim, o_highside_slope_trim;
  integer fails, n_tests, seed, cycles, i, p;
  reg [31:0] r;
  reg [7:0] d, a, b, c, e;
  reg [4:0] m;
  reg hp;

  cwh_ctrl cwh_ctrl_i (.*);
  cwh_host cwh_host_i (.i_core_clk(i_core_clk), .i_rdata(o_rdata), .o_addr(i_addr), .o_wdata(i_wdata),
    .o_wr(i_wr), .o_rd(i_rd));

  initial begin
    i_core_clk = 1'b0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // expected magnitude times envelope; points 5..7 of each half fold back onto 3..1
  function [12:0] level_of(input [3:0] pt);
    reg [2:0] q;
    reg [12:0] lv;
    begin
      q = (pt[2:0] > 3'h4) ? 3'h0 - pt[2:0] : pt[2:0];
      case (q)
        3'h0: lv = 13'h0000;
        3'h1: lv = ({8'h00, m} * a) >> 8;
        3'h2: lv = ({8'h00, m} * b) >> 8;
        3'h3: lv = ({8'h00, m} * c) >> 8;
        default: lv = {8'h00, m};
      endcase
      level_of = lv * e;
    end
  endfunction
  task report_and_stop;
    begin
      if (fails == 0 && n_tests > 0) begin
        $display("Finished cleanly");
      end else begin
        $display("Finished with errors");
      end
      $finish;
    end
  endtask
  task do_reset;
    begin
      @(posedge i_core_clk);
      i_nrst <= 1'b0;
      repeat (4) @(posedge i_core_clk);
      i_nrst <= 1'b1;
    end
  endtask
  task pulse(input [4:0] v);
    begin
      @(posedge i_core_clk);
      ev <= v;
      @(posedge i_core_clk);
      ev <= 5'h00;
    end
  endtask
  task chk_rd(input [7:0] ad, input [7:0] ex);
    begin
      cwh_host_i.rd(ad, d);
      `CHK(d, ex)
    end
  endtask
  // one full period sampled mid-point; level lags the point by one clock
  task shape_run(input ovr);
    begin
      cwh_host_i.wr(`CWH_ADDR_MAXCUR, {3'h0, m});
      cwh_host_i.wr(`CWH_ADDR_COEF1, a);
      cwh_host_i.wr(`CWH_ADDR_COEF2, b);
      cwh_host_i.wr(`CWH_ADDR_COEF3, c);
      cwh_host_i.set_override(e);
      i_env_amp <= ovr ? ~e : e;
      cwh_host_i.setup_custom(1'b0, ovr);
      pulse(5'h01);
      for (p = 0; p < 16; p = p + 1) begin
        repeat (2) @(posedge i_core_clk);
        @(negedge i_core_clk);
        `CHK(o_drive_level, level_of(p[3:0]))
        `CHK(o_drive_negative, p[3])
        `CHK(o_half_period, hp ^ ~p[3])
        repeat (2) @(posedge i_core_clk);
      end
      // start, point 8 and the wrap to point 0 give three toggles per run
      hp = ~hp;
      pulse(5'h02);
    end
  endtask
  always @(posedge i_core_clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      report_and_stop;
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 68;
    fails = 0;
    n_tests = 0;
    cycles = 0;
    hp = 1'b0;
    i_nrst = 1'b0;
    ev = 5'h00;
    i_env_amp = 8'h00;
    i_period_cycles = 16'h0040;
    do_reset;
    chk_rd(`CWH_ADDR_CTRL, `CWH_RST_CTRL);
    chk_rd(`CWH_ADDR_MAXCUR, {3'h0, `CWH_RST_MAXCUR});
    chk_rd(`CWH_ADDR_COEF1, `CWH_RST_COEF1);
    chk_rd(`CWH_ADDR_COEF2, `CWH_RST_COEF2);
    chk_rd(`CWH_ADDR_COEF3, `CWH_RST_COEF3);
    chk_rd(`CWH_ADDR_UVLO, {6'h00, `CWH_RST_UVLO});
    chk_rd(`CWH_ADDR_SLOPE, {4'h0, `CWH_RST_SLOPE});
    chk_rd(`CWH_ADDR_MASK1, 8'h00);
    chk_rd(`CWH_ADDR_MASK2, 8'h00);
    cwh_host_i.wr(8'h07, 8'hFF);
    cwh_host_i.wr(`CWH_ADDR_STATUS, 8'hFF);
    chk_rd(8'h07, 8'h00);
    chk_rd(`CWH_ADDR_STATUS, 8'h00);
    m = `CWH_RST_MAXCUR;
    a = `CWH_RST_COEF1;
    b = `CWH_RST_COEF2;
    c = `CWH_RST_COEF3;
    e = 8'hFF;
    shape_run(1'b0);
    @(negedge i_core_clk);
    `CHK({o_amplitude_regulator_enable, o_impedance_factor_hold, o_motion_sense_enable, o_wave_shape_select}, 4'h5)
    `CHK(o_irq, 1'b1)
    chk_rd(`CWH_ADDR_EVT1, 8'h08);
    for (i = 0; i < 3; i = i + 1) begin
      {a, b, c, e} = $random(seed);
      r = $random(seed);
      m = r[4:0];
      shape_run(i[0]);
    end
    cwh_host_i.wr(`CWH_ADDR_EVT1, 8'h0F);
    cwh_host_i.wr(`CWH_ADDR_EVT2, 8'h03);
    chk_rd(`CWH_ADDR_EVT1, 8'h00);
    `CHK(o_irq, 1'b0)
    for (i = 0; i < 3; i = i + 1) begin
      pulse(5'h04 << i);
      @(negedge i_core_clk);
      `CHK(o_irq, 1'b1)
      cwh_host_i.wr(`CWH_ADDR_MASK1, 8'h01 << i);
      @(negedge i_core_clk);
      `CHK(o_irq, 1'b0)
      pulse(5'h01);
      chk_rd(`CWH_ADDR_EVT2, 8'h02);
      `CHK(o_current_loop_en, 1'b0)
      cwh_host_i.wr(`CWH_ADDR_EVT1, 8'h01 << i);
      cwh_host_i.wr(`CWH_ADDR_EVT2, 8'h02);
      cwh_host_i.wr(`CWH_ADDR_MASK1, 8'h00);
      chk_rd(`CWH_ADDR_EVT1, 8'h00);
    end
    for (i = 0; i < 4; i = i + 1) begin
      r = $random(seed);
      cwh_host_i.wr(`CWH_ADDR_UVLO, r[7:0]);
      cwh_host_i.wr(`CWH_ADDR_SLOPE, r[15:8]);
      cwh_host_i.loop_setup(12 + i * 11, i * 700, i[1:0]);
      @(negedge i_core_clk);
      `CHK(o_undervoltage_threshold, r[1:0])
      `CHK({o_highside_slope_trim, o_lowside_slope_trim}, r[11:8])
      `CHK(o_loop_cap_trim, 2'h3 - i[1:0])
      `CHK(o_loop_res_trim, i[1:0])
      `CHK(o_loop_narrow_bandwidth, i > 1)
    end
    cwh_host_i.setup_custom(1'b1, 1'b0);
    cwh_host_i.wr(`CWH_ADDR_MASK2, 8'h03);
    pulse(5'h01);
    @(negedge i_core_clk);
    `CHK(o_current_loop_en, 1'b1)
    pulse(5'h04);
    repeat (3) @(posedge i_core_clk);
    chk_rd(`CWH_ADDR_EVT1, 8'h00);
    `CHK(o_irq, 1'b0)
    chk_rd(`CWH_ADDR_EVT2, 8'h01);
    // a period under 16 clocks falls back to one clock per point
    i_period_cycles <= 16'h0007;
    pulse(5'h01);
    @(negedge i_core_clk);
    `CHK(o_current_loop_en, 1'b1)
    repeat (40) @(posedge i_core_clk);
    pulse(5'h02);
    do_reset;
    chk_rd(`CWH_ADDR_CTRL, `CWH_RST_CTRL);
    chk_rd(`CWH_ADDR_EVT2, 8'h00);
    report_and_stop;
  end
endmodule
